// ==== rxd_engine.v ====
// receive descriptor walker and rx_status_word write-back
//
// Local design decisions: the plain strobed port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
// How it works
// R1 - separate receive and transmit list bases held in rx_list_base_reg, tx_list_base_reg
// R2 - next descriptor by ring step, wrap at ring end, or chain bit 24
// R3 - each descriptor feeds at most two buffers with own size and address
// R4 - a buffer holds one frame or part of it; frames span descriptors
// R5 - host places descriptors and receive buffers on longword addresses
// R6 - buffers get frame data only; status goes to the descriptor
// R7 - bit 31 ownership; cleared on frame end or buffers full
// R8 - bits 30:16 carry frame length including crc
// R9 - error summary is or of overflow, crc, collision, too long, runt, shortfall
// R10 - shortfall set and frame truncated when next descriptor not owned
// R11 - bits 13:12 give frame origin: serial, internal or external loopback
// R12 - origin code 10 comes only from operating mode bits 11:10
// R13 - runt flag only without overflow; runts kept only with pass-bad set (truncated runts are kept without it)
// R14 - group address flag for multicast destination
// R15 - start flag on descriptor with first data; zero sizes skip ahead
// R16 - end flag on descriptor holding the frame's final part
// R17 - per-frame flags meaningful only where end flag is set
// R18 - oversize flag above 1518 bytes, no truncation
// R19 - late collision flag passed into status
// R20 - status lands in the same write that clears ownership
`include "rxd_consts.vh"
module rxd_engine
#(
  parameter AW = 32
)
(
  input  wire          clock_i,
  input  wire          rstn_i,
  input  wire [7:0]    reg_addr_i,
  input  wire [31:0]   reg_wdata_i,
  input  wire          reg_wr_i,
  input  wire          reg_rd_i,
  output reg  [31:0]   reg_rdata_o,
  output reg           mem_req_o,
  output reg           mem_we_o,
  output reg  [AW-1:0] mem_addr_o,
  output reg  [31:0]   mem_wdata_o,
  input  wire          mem_ack_i,
  input  wire [31:0]   mem_rdata_i,
  input  wire [31:0]   rx_data_i,
  input  wire          rx_valid_i,
  input  wire          rx_last_i,
  input  wire [2:0]    rx_bytes_i,
  input  wire          rx_overflow_i,
  input  wire          rx_crc_err_i,
  input  wire          rx_late_col_i,
  input  wire          rx_runt_i,
  input  wire          rx_multicast_i,
  output reg           rx_ready_o
);

  localparam [3:0] S_IDLE  = 4'h0;
  localparam [3:0] S_OWN   = 4'h1;
  localparam [3:0] S_CTL   = 4'h2;
  localparam [3:0] S_B1    = 4'h3;
  localparam [3:0] S_B2    = 4'h4;
  localparam [3:0] S_DATA  = 4'h5;
  localparam [3:0] S_NEXT  = 4'h6;
  localparam [3:0] S_DRAIN = 4'h7;
  localparam [3:0] S_STAT  = 4'h8;
  localparam [3:0] S_SUSP  = 4'h9;

  reg [3:0]            state;
  reg [31:0]           rx_list_base_reg;
  reg [31:0]           tx_list_base_reg;
  reg [31:0]           operating_mode_reg;
  reg [AW-1:0]         cur_addr;
  reg [AW-1:0]         frame_desc;
  reg [`RXD_SZ_W-1:0]  sz1;
  reg [`RXD_SZ_W-1:0]  sz2;
  reg [`RXD_SZ_W-1:0]  rem;
  reg                  chain;
  reg                  ring_end;
  reg [AW-1:0]         b1_addr;
  reg [AW-1:0]         b2_addr;
  reg [AW-1:0]         buf_ptr;
  reg                  buf_sel;
  reg                  in_frame;
  reg                  fs_here;
  reg                  got_last;
  reg                  is_last;
  reg                  trunc;
  reg [`RXD_LEN_W-1:0] flen;
  reg                  f_of;
  reg                  f_ce;
  reg                  f_cs;
  reg                  f_runt;
  reg                  f_mf;
  reg [15:0]           frame_cnt;

  wire                 pass_bad = operating_mode_reg[`RXD_MODE_PASS_BAD];
  wire [1:0]           op_mode  = operating_mode_reg[`RXD_MODE_OP_HI:`RXD_MODE_OP_LO];
  wire                 accept   = rx_valid_i & rx_ready_o;

  // next descriptor: chained, wrapped to the list base, or one step on [R2]
  wire [AW-1:0] nxt_addr = chain    ? b2_addr :
                           ring_end ? rx_list_base_reg[AW-1:0] :
                           cur_addr + `RXD_DESC_STEP;

  // origin follows the mode setting only, not the frame itself [R11] [R12]
  wire [1:0] dt = (op_mode == `RXD_OP_NORMAL)   ? `RXD_DT_SERIAL :
                  (op_mode == `RXD_OP_INT_LOOP) ? `RXD_DT_INT_LOOP :
                  `RXD_DT_EXT_LOOP;

  wire rf = f_runt & ~f_of;                       // [R13]
  wire tl = (flen > `RXD_MAX_LEN);                // [R18]
  wire es = f_of | f_ce | f_cs | tl | rf | trunc; // [R9]

  // frame flags only travel in the closing descriptor [R16] [R17]
  wire [31:0] stat_last = {1'b0, flen, es, trunc, dt, rf, f_mf, fs_here,
                           1'b1, tl, f_cs, 2'h0, 1'b1, 1'b0, f_ce, f_of};
  wire [31:0] stat_part = {1'b0, {`RXD_LEN_W{1'b0}}, 6'h00, fs_here,
                           1'b0, 8'h00};
  wire drop_runt = rf & ~pass_bad & ~trunc;       // [R13]
  wire [2:0] nbytes = rx_last_i ? rx_bytes_i : 3'h4;

  // register reads answer one cycle after the strobe
  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
      reg_rdata_o <= 32'h0000_0000;
    else if (reg_rd_i)
    begin
      case (reg_addr_i)
        `RXD_OFF_RX_BASE:  reg_rdata_o <= rx_list_base_reg;
        `RXD_OFF_TX_BASE:  reg_rdata_o <= tx_list_base_reg;
        `RXD_OFF_MODE:     reg_rdata_o <= operating_mode_reg;
        `RXD_OFF_CUR_DESC: reg_rdata_o <= cur_addr;
        `RXD_OFF_STATUS:   reg_rdata_o <= {frame_cnt, 12'h000, state};
        default:           reg_rdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // list bases and mode; low address bits forced clear for alignment
  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rx_list_base_reg   <= 32'h0000_0000;
      tx_list_base_reg   <= 32'h0000_0000;
      operating_mode_reg <= `RXD_MODE_RESET;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == `RXD_OFF_RX_BASE)
        rx_list_base_reg <= {reg_wdata_i[31:2], 2'h0}; // [R1] [R5]
      if (reg_addr_i == `RXD_OFF_TX_BASE)
        tx_list_base_reg <= {reg_wdata_i[31:2], 2'h0}; // [R1] [R5]
      if (reg_addr_i == `RXD_OFF_MODE)
        operating_mode_reg <= reg_wdata_i;
    end
  end

  // descriptor walker; one memory request outstanding at a time
  always @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state       <= S_IDLE;
      mem_req_o   <= 1'b0;
      mem_we_o    <= 1'b0;
      mem_addr_o  <= {AW{1'b0}};
      mem_wdata_o <= 32'h0000_0000;
      rx_ready_o  <= 1'b0;
      cur_addr    <= {AW{1'b0}};
      frame_desc  <= {AW{1'b0}};
      sz1         <= {`RXD_SZ_W{1'b0}};
      sz2         <= {`RXD_SZ_W{1'b0}};
      rem         <= {`RXD_SZ_W{1'b0}};
      chain       <= 1'b0;
      ring_end    <= 1'b0;
      b1_addr     <= {AW{1'b0}};
      b2_addr     <= {AW{1'b0}};
      buf_ptr     <= {AW{1'b0}};
      buf_sel     <= 1'b0;
      in_frame    <= 1'b0;
      fs_here     <= 1'b0;
      got_last    <= 1'b0;
      is_last     <= 1'b0;
      trunc       <= 1'b0;
      flen        <= {`RXD_LEN_W{1'b0}};
      f_of        <= 1'b0;
      f_ce        <= 1'b0;
      f_cs        <= 1'b0;
      f_runt      <= 1'b0;
      f_mf        <= 1'b0;
      frame_cnt   <= 16'h0000;
    end
    else
    begin
      rx_ready_o <= 1'b0;
      // a base write while parked restarts the walk at the list head
      if (reg_wr_i && reg_addr_i == `RXD_OFF_RX_BASE &&
          (state == S_IDLE || state == S_SUSP))
        cur_addr <= {reg_wdata_i[AW-1:2], 2'h0};
      // frame bytes counted in both data and drain; flags caught at end
      if (accept)
      begin
        flen <= flen + {{(`RXD_LEN_W-3){1'b0}}, nbytes}; // [R8]
        if (rx_last_i)
        begin
          got_last <= 1'b1;
          f_of     <= rx_overflow_i;
          f_ce     <= rx_crc_err_i;
          f_cs     <= rx_late_col_i;  // [R19]
          f_runt   <= rx_runt_i;
          f_mf     <= rx_multicast_i; // [R14]
        end
      end
      case (state)
        S_IDLE:
        begin
          if (operating_mode_reg[`RXD_MODE_START] && rx_valid_i)
          begin
            state      <= S_OWN;
            mem_req_o  <= 1'b1;
            mem_we_o   <= 1'b0;
            mem_addr_o <= cur_addr;
          end
        end
        S_OWN:
        begin
          if (mem_ack_i)
          begin
            if (mem_rdata_i[`RXD_ST_OWN])          // [R7]
            begin
              state      <= S_CTL;
              frame_desc <= cur_addr;
              mem_addr_o <= cur_addr + `RXD_W_CTL;
            end
            else
            begin
              state     <= S_SUSP;
              mem_req_o <= 1'b0;
            end
          end
        end
        S_CTL:
        begin
          if (mem_ack_i)
          begin
            sz1        <= mem_rdata_i[`RXD_CT_SZ1_HI:`RXD_CT_SZ1_LO]; // [R3]
            sz2        <= mem_rdata_i[`RXD_CT_SZ2_HI:`RXD_CT_SZ2_LO]; // [R3]
            chain      <= mem_rdata_i[`RXD_CT_CHAIN];    // [R2]
            ring_end   <= mem_rdata_i[`RXD_CT_RING_END]; // [R2]
            state      <= S_B1;
            mem_addr_o <= cur_addr + `RXD_W_B1;
          end
        end
        S_B1:
        begin
          if (mem_ack_i)
          begin
            b1_addr    <= {mem_rdata_i[AW-1:2], 2'h0};
            state      <= S_B2;
            mem_addr_o <= cur_addr + `RXD_W_B2;
          end
        end
        S_B2:
        begin
          if (mem_ack_i)
          begin
            b2_addr   <= {mem_rdata_i[AW-1:2], 2'h0};
            buf_sel   <= 1'b0;
            buf_ptr   <= b1_addr;
            rem       <= sz1; // zero size falls straight to buffer two [R15]
            mem_req_o <= 1'b0;
            state     <= S_DATA;
          end
        end
        S_DATA:
        begin
          if (mem_req_o)
          begin
            if (mem_ack_i)
            begin
              mem_req_o <= 1'b0;
              if (got_last)
              begin
                is_last <= 1'b1;
                state   <= S_STAT;
              end
            end
          end
          else if (rem == {`RXD_SZ_W{1'b0}})
          begin
            // second buffer is the next link when chaining [R2] [R3]
            if (!buf_sel && !chain && sz2 != {`RXD_SZ_W{1'b0}})
            begin
              buf_sel <= 1'b1;
              buf_ptr <= b2_addr;
              rem     <= sz2;
            end
            else
            begin
              // buffers full mid-frame: look at next ownership first [R10]
              state      <= S_NEXT;
              mem_req_o  <= 1'b1;
              mem_we_o   <= 1'b0;
              mem_addr_o <= nxt_addr;
            end
          end
          else if (accept)
          begin
            // frame data only goes to the buffer [R4] [R6]
            mem_req_o   <= 1'b1;
            mem_we_o    <= 1'b1;
            mem_addr_o  <= buf_ptr;
            mem_wdata_o <= rx_data_i;
            buf_ptr     <= buf_ptr + `RXD_WORD_BYTES;
            rem         <= (rem > `RXD_WORD_BYTES) ? rem - `RXD_WORD_BYTES :
                           {`RXD_SZ_W{1'b0}};
            in_frame    <= 1'b1;
            if (!in_frame)
              fs_here <= 1'b1; // [R15]
          end
          else
            rx_ready_o <= 1'b1;
        end
        S_NEXT:
        begin
          if (mem_ack_i)
          begin
            if (mem_rdata_i[`RXD_ST_OWN])
            begin
              // close this one without end flag, frame carries on [R4]
              is_last     <= 1'b0;
              state       <= S_STAT;
              mem_we_o    <= 1'b1;
              mem_addr_o  <= cur_addr;
              mem_wdata_o <= stat_part; // [R7] [R20]
            end
            else if (in_frame)
            begin
              trunc     <= 1'b1; // rest of frame is thrown away [R10]
              mem_req_o <= 1'b0;
              state     <= S_DRAIN;
            end
            else
            begin
              mem_req_o <= 1'b0;
              state     <= S_SUSP;
            end
          end
        end
        S_DRAIN:
        begin
          if (got_last)
          begin
            is_last <= 1'b1;
            state   <= S_STAT;
          end
          else if (!accept)
            rx_ready_o <= 1'b1;
        end
        S_STAT:
        begin
          if (!mem_req_o)
          begin
            if (drop_runt)
            begin
              // untruncated runt without pass-bad: reuse its descriptor [R13]
              cur_addr <= frame_desc;
              in_frame <= 1'b0;
              fs_here  <= 1'b0;
              got_last <= 1'b0;
              flen     <= {`RXD_LEN_W{1'b0}};
              state    <= S_IDLE;
            end
            else
            begin
              // status and cleared ownership in one write [R7] [R20]
              mem_req_o   <= 1'b1;
              mem_we_o    <= 1'b1;
              mem_addr_o  <= cur_addr;
              mem_wdata_o <= stat_last; // [R8] [R16]
            end
          end
          else if (mem_ack_i)
          begin
            cur_addr <= nxt_addr; // [R2]
            fs_here  <= 1'b0;
            if (is_last)
            begin
              mem_req_o <= 1'b0;
              in_frame  <= 1'b0;
              got_last  <= 1'b0;
              trunc     <= 1'b0;
              flen      <= {`RXD_LEN_W{1'b0}};
              frame_cnt <= frame_cnt + 16'h0001;
              state     <= S_IDLE;
            end
            else
            begin
              // ownership already seen, go on to its control word
              mem_we_o   <= 1'b0;
              mem_addr_o <= nxt_addr + `RXD_W_CTL;
              state      <= S_CTL;
            end
          end
        end
        S_SUSP:
        begin
          // host hands over descriptors, then pokes the poll offset
          if (reg_wr_i && reg_addr_i == `RXD_OFF_POLL)
            state <= in_frame ? S_DRAIN : S_IDLE;
        end
        default:
        begin
          state     <= S_IDLE;
          mem_req_o <= 1'b0;
        end
      endcase
    end
  end

endmodule // rxd_engine
`default_nettype wire

// ==== rxd_consts.vh ====
// constants for the receive descriptor status engine
`ifndef RXD_CONSTS_VH
`define RXD_CONSTS_VH
// register byte offsets on the plain register port
`define RXD_OFF_RX_BASE   8'h00
`define RXD_OFF_TX_BASE   8'h04
`define RXD_OFF_MODE      8'h08
`define RXD_OFF_CUR_DESC  8'h0c
`define RXD_OFF_STATUS    8'h10
`define RXD_OFF_POLL      8'h14
// operating_mode_reg fields and reset value
`define RXD_MODE_RESET    32'h0000_0000
`define RXD_MODE_START    1
`define RXD_MODE_PASS_BAD 3
`define RXD_MODE_OP_HI    11
`define RXD_MODE_OP_LO    10
// rx_status_word fields
`define RXD_ST_OWN        31
`define RXD_ST_LEN_HI     30
`define RXD_ST_LEN_LO     16
`define RXD_LEN_W         15
// rx_control_word fields
`define RXD_CT_SZ1_HI     10
`define RXD_CT_SZ1_LO     0
`define RXD_CT_SZ2_HI     21
`define RXD_CT_SZ2_LO     11
`define RXD_CT_RING_END   25
`define RXD_CT_CHAIN      24
`define RXD_SZ_W          11
// frame_origin_code values
`define RXD_DT_SERIAL     2'h0
`define RXD_DT_INT_LOOP   2'h1
`define RXD_DT_EXT_LOOP   2'h2
`define RXD_OP_NORMAL     2'h0
`define RXD_OP_INT_LOOP   2'h1
// descriptor layout and limits
`define RXD_W_CTL         32'h0000_0004
`define RXD_W_B1          32'h0000_0008
`define RXD_W_B2          32'h0000_000c
`define RXD_DESC_STEP     32'h0000_0010
`define RXD_WORD_BYTES    11'h004
`define RXD_MAX_LEN       15'h05ee
`endif

// ==== rxd_engine_monitor.sv ====
// assertion checker bound to the receive descriptor engine
`timescale 1ns/100ps
`default_nettype none
module rxd_engine_chk
#(
  parameter AW = 32
)
(
  input wire logic          clock_i,
  input wire logic          rstn_i,
  input wire logic [7:0]    reg_addr_i,
  input wire logic [31:0]   reg_wdata_i,
  input wire logic          reg_wr_i,
  input wire logic          reg_rd_i,
  input wire logic [31:0]   reg_rdata_o,
  input wire logic          mem_req_o,
  input wire logic          mem_we_o,
  input wire logic [AW-1:0] mem_addr_o,
  input wire logic [31:0]   mem_wdata_o,
  input wire logic          mem_ack_i
);
  logic [AW-1:0] cur_desc;
  logic [31:0]   base;
  logic [1:0]    op;
  logic          st;
  logic [31:0]   w;
  // status write: accepted write to the descriptor whose control word was read
  assign st = mem_req_o && mem_we_o && mem_ack_i && mem_addr_o == cur_desc;
  assign w = mem_wdata_o;
  // shadows; assumes 16-byte aligned ring descriptors, chained lists are not tracked
  always @(posedge clock_i or negedge rstn_i)
    if (!rstn_i)
    begin
      cur_desc <= '0;
      base <= 32'h0;
      op <= 2'h0;
    end
    else
    begin
      if (mem_req_o && !mem_we_o && mem_ack_i && mem_addr_o[3:0] == 4'h4)
        cur_desc <= {mem_addr_o[AW-1:4], 4'h0};
      if (reg_wr_i && reg_addr_i == 8'h00)
        base <= {reg_wdata_i[31:2], 2'h0}; // list bases are longword aligned
      if (reg_wr_i && reg_addr_i == 8'h08)
        op <= reg_wdata_i[11:10];
    end
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);
  property p_own;
    st |-> !w[31];
  endproperty
  a_own: assert property (p_own) else $error("status keeps ownership");
  property p_sum;
    st && w[8] |-> w[15] == (w[0] | w[1] | w[6] | w[7] | w[11] | w[14]);
  endproperty
  a_sum: assert property (p_sum) else $error("bad error summary");
  property p_org;
    st && w[8] |-> w[13:12] != 2'h3;
  endproperty
  a_org: assert property (p_org) else $error("reserved origin code");
  property p_mode;
    st && w[8] |-> w[13:12] == (op[1] ? 2'h2 : op);
  endproperty
  a_mode: assert property (p_mode) else $error("origin not from mode");
  property p_runt;
    st && w[8] && w[0] |-> !w[11];
  endproperty
  a_runt: assert property (p_runt) else $error("runt with overflow");
  property p_big;
    st && w[8] && !w[14] |-> w[7] == (w[30:16] > 15'h5ee);
  endproperty
  a_big: assert property (p_big) else $error("oversize flag wrong");
  property p_part;
    st && !w[8] |-> (w & 32'hffff_fdff) == 32'h0;
  endproperty
  a_part: assert property (p_part) else $error("partial status dirty");
  property p_short;
    st && w[14] |-> w[8] && w[15];
  endproperty
  a_short: assert property (p_short) else $error("shortfall not final");
  property p_base;
    reg_rd_i && reg_addr_i == 8'h00 |=> reg_rdata_o == $past(base);
  endproperty
  a_base: assert property (p_base) else $error("list base readback");
  property p_hold;
    mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o) && $stable(mem_wdata_o);
  endproperty
  a_hold: assert property (p_hold) else $error("request changed early");
endmodule // rxd_engine_chk
bind rxd_engine rxd_engine_chk #(.AW(AW)) u_chk (.clock_i(clock_i), .rstn_i(rstn_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .mem_req_o(mem_req_o),
  .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
  .mem_ack_i(mem_ack_i));
`default_nettype wire

// ==== rxd_host_mem.sv ====
// host memory model answering descriptor and buffer accesses
`timescale 1ns/100ps
`default_nettype none
module rxd_host_mem
(
  input  wire logic        clock_i,
  input  wire logic        rstn_i,
  input  wire logic        slow_i,
  input  wire logic        mem_req_i,
  input  wire logic        mem_we_i,
  input  wire logic [31:0] mem_addr_i,
  input  wire logic [31:0] mem_wdata_i,
  output logic             mem_ack_o,
  output logic [31:0]      mem_rdata_o
);
  logic [31:0] words [0:4095];
  logic [31:0] last;
  logic [1:0]  wait_cnt;
  // slow mode keeps the engine waiting three cycles per access
  assign mem_ack_o = mem_req_i && (!slow_i || wait_cnt == 2'h3);
  // data only with the ack, else the inverse of the last word
  assign mem_rdata_o = mem_ack_o ? words[mem_addr_i[13:2]] : ~last;
  // accept writes and count wait cycles
  always @(posedge clock_i or negedge rstn_i)
    if (!rstn_i)
    begin
      wait_cnt <= 2'h0;
      last <= 32'h0;
    end
    else if (mem_ack_o)
    begin
      wait_cnt <= 2'h0;
      last <= mem_rdata_o;
      if (mem_we_i)
        words[mem_addr_i[13:2]] <= mem_wdata_i;
    end
    else if (mem_req_i)
      wait_cnt <= wait_cnt + 2'h1;
endmodule // rxd_host_mem
`default_nettype wire

// ==== tb_rxd_engine.sv ====
// self-checking bench for the receive descriptor engine
`timescale 1ns/100ps
`default_nettype none
module tb_rxd_engine;
  logic        clock_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic        mem_req_o;
  logic        mem_we_o;
  logic        mem_ack_i;
  logic [31:0] mem_addr_o;
  logic [31:0] mem_wdata_o;
  logic [31:0] mem_rdata_i;
  logic [31:0] rx_data_i = 32'h0;
  logic        rx_valid_i = 1'b0;
  logic        rx_last_i = 1'b0;
  logic [2:0]  rx_bytes_i = 3'h4;
  logic [4:0]  flags = 5'h00;   // multicast, runt, late col, crc, overflow
  logic        rx_ready_o;
  logic        slow = 1'b0;
  logic        rd_seen = 1'b0;
  logic [95:0] e;
  logic [95:0] wq [$];          // address, data, compare mask
  logic [31:0] rq [$];
  integer      fails = 0;
  integer      check_count = 0;
  integer      seed = 32'h82bf87e9;
  always #2.5 clock_i = ~clock_i;
  rxd_engine #(.AW(32)) DUT (.clock_i(clock_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i), .rx_data_i(rx_data_i), .rx_valid_i(rx_valid_i),
    .rx_last_i(rx_last_i), .rx_bytes_i(rx_bytes_i), .rx_overflow_i(flags[0]),
    .rx_crc_err_i(flags[1]), .rx_late_col_i(flags[2]), .rx_runt_i(flags[3]),
    .rx_multicast_i(flags[4]), .rx_ready_o(rx_ready_o));
  rxd_host_mem host (.clock_i(clock_i), .rstn_i(rstn_i), .slow_i(slow),
    .mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
    .mem_wdata_i(mem_wdata_o), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    check_count = check_count + 1;
    if ((got & m) !== (exp & m))
    begin
      fails = fails + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // a wait that ran out is a mismatch and ends the run
  task automatic timeout(input logic bad);
    if (bad)
    begin
      cmp(32'h0, 32'h1, 32'hffff_ffff);
      give_verdict;
    end
  endtask
  // oldest note is compared when a write is accepted or read data stand
  always @(posedge clock_i)
  begin
    rd_seen <= reg_rd_i;
    if (rd_seen)
      cmp(reg_rdata_o, rq.pop_front(), 32'hffff_ffff);
    if (mem_req_o === 1'b1 && mem_we_o === 1'b1 && mem_ack_i === 1'b1)
    begin
      e = (wq.size() > 0) ? wq.pop_front() : {96{1'b1}};
      cmp(mem_addr_o, e[95:64], 32'hffff_ffff);
      cmp(mem_wdata_o, e[63:32], e[31:0]);
    end
  end
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clock_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
    rq.push_back(exp);
    @(posedge clock_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clock_i);
    reg_rd_i <= 1'b0;
  endtask
  // lays a descriptor, sends one frame, notes each buffer and status write
  task automatic frame(input int i, input logic [1:0] op, input logic [10:0] s1,
                       input logic [10:0] s2, input int nw, input logic [2:0] lb);
    logic [31:0] d;
    logic [31:0] b;
    logic [31:0] x;
    logic [31:0] m;
    logic [4:0]  fl;
    logic [14:0] len;
    logic        de;
    logic        tl;
    logic        rf;
    int          n;
    int          k;
    d = 32'h100 + i * 16;
    b = 32'h1000 + i * 32'h800;
    x = $random(seed);
    fl = x[4:0];
    de = nw * 4 > s1 + s2;
    len = nw * 4 - 4 + lb;
    tl = len > 15'h5ee;
    rf = fl[3] & ~fl[0];
    host.words[d[13:2]] = 32'h8000_0000;
    host.words[d[13:2] + 1] = {10'h0, s2, s1};
    host.words[d[13:2] + 2] = b;
    host.words[d[13:2] + 3] = b + 32'h600;
    reg_wr(8'h14, 32'h0); // a parked walk retries once the descriptor is owned
    reg_wr(8'h08, {20'h0, op, 10'h00a});
    for (n = 0; n < nw; n++)
    begin
      x = $random(seed);
      m = (n < nw - 1 || lb == 3'h4) ? 32'hffff_ffff : ~(32'hffff_ffff << (lb * 8));
      if (n * 4 < s1)
        wq.push_back({b + n * 4, x, m});
      else if (n * 4 < s1 + s2)
        wq.push_back({b + 32'h600 + n * 4 - s1, x, m});
      rx_data_i <= x;
      rx_valid_i <= 1'b1;
      rx_last_i <= n == nw - 1;
      rx_bytes_i <= lb;
      flags <= fl;
      k = 0;
      do
      begin
        @(posedge clock_i);
        k++;
      end
      while (rx_ready_o !== 1'b1 && k < 300);
      timeout(rx_ready_o !== 1'b1);
    end
    rx_valid_i <= 1'b0;
    rx_last_i <= 1'b0;
    wq.push_back({d, 1'b0, len, fl[0] | fl[1] | fl[2] | tl | rf | de, de,
                  op[1] ? 2'h2 : op, rf, fl[4], 2'h3, tl, fl[2], 4'h2, fl[1], fl[0],
                  de ? 32'h8000_ffff : 32'hffff_ffff});
    k = 0;
    while (wq.size() != 0 && k < 500)
    begin
      @(posedge clock_i);
      k++;
    end
    timeout(wq.size() != 0);
  endtask
  // reset, registers, then frames over all origin modes and unchained two-buffer layouts
  initial
  begin
    repeat (6) @(posedge clock_i);
    rstn_i <= 1'b1;
    host.words[12'h050] = 32'h0; // fifth descriptor stays with the host
    reg_rd(8'h08, 32'h0);
    reg_rd(8'h18, 32'h0);
    reg_wr(8'h00, 32'h100);
    reg_wr(8'h04, 32'h800);
    reg_rd(8'h00, 32'h100);
    reg_rd(8'h04, 32'h800);
    frame(0, 2'h0, 11'h008, 11'h008, 3, 3'h2);
    slow <= 1'b1;
    frame(1, 2'h1, 11'h000, 11'h010, 3, 3'h4);
    slow <= 1'b0;
    frame(2, 2'h2, 11'h5f0, 11'h000, 380, 3'h4);
    frame(3, 2'h3, 11'h008, 11'h004, 5, 3'h3);
    // next descriptor still host-owned: the walk parks until a poll
    rx_valid_i <= 1'b1;
    repeat (20) @(posedge clock_i);
    reg_rd(8'h10, 32'h0004_0009);
    reg_rd(8'h0c, 32'h0000_0140);
    frame(4, 2'h1, 11'h004, 11'h00c, 4, 3'h1);
    give_verdict;
  end
endmodule // tb_rxd_engine
`default_nettype wire
